// file: core/mhbp_map.svh
`ifndef MHBP_MAP_SVH
`define MHBP_MAP_SVH

// Clock and reset timing
`define MHBP_CLK_PERIOD_PS 4000
`define MHBP_RST_HOLD_OSC 256
`define MHBP_OSC_PERIOD_PS 100000
`define MHBP_RST_HOLD_PS (`MHBP_RST_HOLD_OSC * `MHBP_OSC_PERIOD_PS)
`define MHBP_RST_HOLD_CYCLES ((`MHBP_RST_HOLD_PS + `MHBP_CLK_PERIOD_PS - 1) / `MHBP_CLK_PERIOD_PS)
`define MHBP_RST_CNT_W 16

// Strap settle time after reset release, in cycles
`define MHBP_STRAP_SETTLE 3'h7

// Data buffer depth
`define MHBP_FIFO_DEPTH 4

// Pin positions on the shared data bus
`define MHBP_SCLK_BIT 7
`define MHBP_SDI_BIT 6
`define MHBP_SDO_BIT 5
`define MHBP_SS_BIT 4
`define MHBP_SCL_BIT 7
`define MHBP_SDA_BIT 6
`define MHBP_ADDR_MSB 5

// Reset values of pulled-up pins and empty data
`define MHBP_PIN_IDLE 16'hFFFF
`define MHBP_BYTE_ZERO 8'h00

`endif

// file: core/mhbp_pkg.sv
package mhbp_pkg;

	// Bus type selected by the strap
	typedef enum logic [2:0] {
		MHBP_M8080 = 3'h0,
		MHBP_M6800 = 3'h1,
		MHBP_SPI3 = 3'h2,
		MHBP_SPI4 = 3'h3,
		MHBP_I2C = 3'h4
	} mhbp_mode_t;

	// Serial engine states
	typedef enum logic [6:0] {
		SER_IDLE = 7'h01,
		SER_ADDR = 7'h02,
		SER_AACK = 7'h04,
		SER_WR = 7'h08,
		SER_WACK = 7'h10,
		SER_RD = 7'h20,
		SER_RACK = 7'h40
	} mhbp_ser_t;

endpackage : mhbp_pkg

// file: core/mhbp_fifo_if.sv
`timescale 1ns/1ps
interface mhbp_fifo_if #(parameter int WIDTH = 9);
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [WIDTH-1:0] out_data;

	modport fifo(input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user(output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : mhbp_fifo_if

// file: core/mhbp_fifo.sv
`timescale 1ns/1ps
`include "mhbp_map.svh"
module mhbp_fifo
	import mhbp_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = `MHBP_FIFO_DEPTH
)
(
	input wire logic i_clock,
	input wire logic i_nrst,
	mhbp_fifo_if.fifo port
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Power-of-two depth keeps pointer wrap free
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
		begin : g_bad
			$error("mhbp_fifo: DEPTH must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	// Honest full and empty from the fill count
	assign port.in_ready = (count != (AW + 1)'(DEPTH));
	assign port.out_valid = (count != '0);
	assign port.out_data = mem[rd_ptr];
	assign push = port.in_valid && port.in_ready;
	assign pop = port.out_valid && port.out_ready;

	// Pointer and count update
	always_comb
	begin
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Storage, written only on an accepted push
	always_ff @(posedge i_clock)
	begin
		if (push)
			mem[wr_ptr] <= port.in_data;
	end
endmodule : mhbp_fifo

// file: core/mhbp_port.sv
`timescale 1ns/1ps
`include "mhbp_map.svh"
// Functional notes
// - host_wait_n low while busy, high when ready to transfer.
// - Active-low irq_n tells the host of internal status conditions.
// - Parallel modes use all eight data lines both ways.
// - cmd_data_sel low marks instruction code, high marks display data.
// - 8080 mode captures write byte on write strobe rising edge.
// - 8080 mode drives read data while read strobe is low.
// - 6800 mode drives read data while enable high, latches write on its fall.
// - Parallel cycles accepted only while parallel_select_n is low.
// - SPI uses bit 7 as clock and bit 4 as serial_select_n.
// - 4-wire SPI: bit 6 data in, bit 5 data out.
// - 3-wire SPI: bit 5 is the shared data line; bit 6 tied high.
// - I2C uses bit 7 as clock from host, bit 6 as SDA.
// - I2C slave address bits 5..0 come from data bus bits 5..0.
// - Serial modes ignore cmd_data_sel, strobes and parallel select.
// - Three-bit strap picks 8080, 6800, SPI3, SPI4 or I2C.
// - Reset pin must stay low 256 oscillator clocks to count.
module mhbp_port
	import mhbp_pkg::*;
#(
	parameter int RST_HOLD_CYCLES = `MHBP_RST_HOLD_CYCLES,
	parameter int FIFO_DEPTH = `MHBP_FIFO_DEPTH,
	parameter logic I2C_ADDR_TOP = 1'b0
)
(
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [7:0] i_host_data_bus,
	output logic [7:0] o_host_data_bus,
	output logic [7:0] o_host_data_oe,
	input wire logic i_cmd_data_sel,
	input wire logic i_write_strobe_n,
	input wire logic i_read_strobe_n,
	input wire logic i_parallel_select_n,
	input wire logic i_host_reset_n,
	input wire logic [2:0] i_bus_mode_strap,
	output logic o_host_wait_n,
	output logic o_irq_n,
	output logic o_host_reset,
	input wire logic i_busy,
	input wire logic i_irq_req,
	input wire logic [7:0] i_status_word,
	input wire logic [7:0] i_read_data,
	output logic o_rd_taken,
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	output logic o_rx_is_data,
	input wire logic i_rx_ready
);
	localparam int NSYNC = 16;
	localparam int CW = `MHBP_RST_CNT_W;

	generate
		if (RST_HOLD_CYCLES < 1 || RST_HOLD_CYCLES >= (1 << CW))
		begin : g_bad
			$error("mhbp_port: RST_HOLD_CYCLES out of range");
		end
	endgenerate

	// Parallel bus types share one read/write engine
	function automatic logic is_parallel(input mhbp_mode_t m);
		return (m == MHBP_M8080) || (m == MHBP_M6800);
	endfunction : is_parallel

	// Strap decode: 00X 8080, 01X 6800, 100 SPI3, 101 SPI4, 11X I2C
	function automatic mhbp_mode_t decode_mode(input logic [2:0] s);
		mhbp_mode_t m;
		m = MHBP_M8080;
		if (!s[2])
			m = s[1] ? MHBP_M6800 : MHBP_M8080;
		else if (s[1])
			m = MHBP_I2C;
		else
			m = s[0] ? MHBP_SPI4 : MHBP_SPI3;
		return m;
	endfunction : decode_mode

	// Three-stage synchronisers; a change counts once stages two and three agree
	logic [NSYNC-1:0] raw, s1, s2, s3, flt, flt_q;
	assign raw = {i_bus_mode_strap, i_host_reset_n, i_parallel_select_n, i_read_strobe_n,
		i_write_strobe_n, i_cmd_data_sel, i_host_data_bus};
	genvar g;
	generate
		for (g = 0; g < NSYNC; g++)
		begin : g_sync
			always_ff @(posedge i_clock or negedge i_nrst)
			begin
				if (!i_nrst)
				begin
					s1[g] <= 1'b1;
					s2[g] <= 1'b1;
					s3[g] <= 1'b1;
					flt[g] <= 1'b1;
					flt_q[g] <= 1'b1;
				end
				else
				begin
					s1[g] <= raw[g];
					s2[g] <= s1[g];
					s3[g] <= s2[g];
					if (s2[g] == s3[g])
						flt[g] <= s3[g];
					flt_q[g] <= flt[g];
				end
			end
		end
	endgenerate

	logic [7:0] bus, bus_q;
	logic cds, wr_n, wr_n_q, rd_n, rd_n_q, cs_n, prst_n;
	logic [2:0] strap;
	assign bus = flt[7:0];
	assign bus_q = flt_q[7:0];
	assign cds = flt[8];
	assign wr_n = flt[9];
	assign wr_n_q = flt_q[9];
	assign rd_n = flt[10];
	assign rd_n_q = flt_q[10];
	assign cs_n = flt[11];
	assign prst_n = flt[12];
	assign strap = flt[15:13];

	// Host reset filter and strap capture
	logic [CW-1:0] rst_cnt, next_rst_cnt;
	logic host_rst, next_host_rst;
	logic [2:0] settle, next_settle;
	mhbp_mode_t mode, next_mode;
	logic [5:0] i2c_addr, next_i2c_addr;
	always_comb
	begin
		next_rst_cnt = rst_cnt;
		next_host_rst = host_rst;
		next_settle = (settle == `MHBP_STRAP_SETTLE) ? settle : settle + 3'h1;
		if (prst_n)
		begin
			next_rst_cnt = '0;
			next_host_rst = 1'b0;
		end
		else if (rst_cnt == CW'(RST_HOLD_CYCLES - 1))
			next_host_rst = 1'b1;
		else
			next_rst_cnt = rst_cnt + 1'b1;
		next_mode = mode;
		next_i2c_addr = i2c_addr;
		if (settle != `MHBP_STRAP_SETTLE || host_rst)
		begin
			next_mode = decode_mode(strap);
			next_i2c_addr = bus[`MHBP_ADDR_MSB:0];
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			rst_cnt <= '0;
			host_rst <= 1'b0;
			settle <= 3'h0;
			mode <= MHBP_M8080;
			i2c_addr <= 6'h00;
		end
		else
		begin
			rst_cnt <= next_rst_cnt;
			host_rst <= next_host_rst;
			settle <= next_settle;
			mode <= next_mode;
			i2c_addr <= next_i2c_addr;
		end
	end

	// Parallel engine: selects, strobes and read drive
	logic par_sel, p_push, p_read, p_done;
	logic [7:0] rd_value;
	always_comb
	begin
		par_sel = is_parallel(mode) && !cs_n && !host_rst;
		rd_value = cds ? i_read_data : i_status_word;
		p_push = 1'b0;
		p_read = 1'b0;
		p_done = 1'b0;
		if (mode == MHBP_M8080)
		begin
			p_push = par_sel && wr_n && !wr_n_q;
			p_read = par_sel && !rd_n;
			p_done = par_sel && rd_n && !rd_n_q;
		end
		else if (mode == MHBP_M6800)
		begin
			// Read pin carries the enable, write pin the direction
			p_push = par_sel && !rd_n && rd_n_q && !wr_n;
			p_read = par_sel && rd_n && wr_n;
			p_done = par_sel && !rd_n && rd_n_q && wr_n;
		end
	end

	// Serial engine: SPI and I2C share one shift path
	mhbp_ser_t st, next_st;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] rx_sh, next_rx_sh, tx_sh, next_tx_sh, rx_new;
	logic first, next_first, rd_frame, next_rd_frame, load_pend, next_load_pend;
	logic sdrv, next_sdrv, s_push, s_done, din, c_rise, c_fall, sda, start, stop;
	logic fifo_ready;
	always_comb
	begin
		next_st = st;
		next_bit_cnt = bit_cnt;
		next_rx_sh = rx_sh;
		next_tx_sh = tx_sh;
		next_first = first;
		next_rd_frame = rd_frame;
		next_load_pend = load_pend;
		next_sdrv = sdrv;
		s_push = 1'b0;
		s_done = 1'b0;
		c_rise = bus[`MHBP_SCLK_BIT] && !bus_q[`MHBP_SCLK_BIT];
		c_fall = !bus[`MHBP_SCLK_BIT] && bus_q[`MHBP_SCLK_BIT];
		sda = bus[`MHBP_SDA_BIT];
		start = bus[`MHBP_SCL_BIT] && bus_q[`MHBP_SCL_BIT] && bus_q[`MHBP_SDA_BIT] && !sda;
		stop = bus[`MHBP_SCL_BIT] && bus_q[`MHBP_SCL_BIT] && !bus_q[`MHBP_SDA_BIT] && sda;
		din = (mode == MHBP_SPI4) ? bus[`MHBP_SDI_BIT] : bus[`MHBP_SDO_BIT];
		rx_new = {rx_sh[6:0], (mode == MHBP_I2C) ? sda : din};
		if (host_rst || is_parallel(mode))
		begin
			next_st = SER_IDLE;
			next_bit_cnt = 4'h0;
			next_first = 1'b1;
			next_rd_frame = 1'b0;
			next_load_pend = 1'b0;
			next_sdrv = 1'b0;
		end
		else if (mode != MHBP_I2C)
		begin
			if (bus[`MHBP_SS_BIT])
			begin
				// Deselected: preload first read byte, restart framing
				next_bit_cnt = 4'h0;
				next_first = 1'b1;
				next_rd_frame = 1'b0;
				next_load_pend = 1'b0;
				next_tx_sh = i_read_data;
			end
			else
			begin
				if (c_rise)
				begin
					next_rx_sh = rx_new;
					next_bit_cnt = bit_cnt + 4'h1;
					if (bit_cnt == 4'h7)
					begin
						next_bit_cnt = 4'h0;
						s_push = 1'b1;
						s_done = rd_frame;
						next_first = 1'b0;
						next_load_pend = 1'b1;
						if (first)
							next_rd_frame = rx_new[7];
					end
				end
				if (c_fall)
				begin
					next_load_pend = 1'b0;
					next_tx_sh = load_pend ? i_read_data : {tx_sh[6:0], 1'b0};
				end
			end
		end
		else if (start)
		begin
			next_st = SER_ADDR;
			next_bit_cnt = 4'h0;
			next_first = 1'b1;
			next_sdrv = 1'b0;
		end
		else if (stop)
		begin
			next_st = SER_IDLE;
			next_sdrv = 1'b0;
		end
		else
		begin
			unique case (st)
				SER_IDLE:
					next_sdrv = 1'b0;
				SER_ADDR, SER_WR:
				begin
					if (c_rise)
					begin
						next_rx_sh = rx_new;
						next_bit_cnt = bit_cnt + 4'h1;
					end
					else if (c_fall && bit_cnt == 4'h8)
					begin
						next_bit_cnt = 4'h0;
						if (st == SER_WR)
						begin
							s_push = 1'b1;
							next_first = 1'b0;
							next_st = SER_WACK;
							next_sdrv = fifo_ready; // Refused byte is answered by NACK
						end
						else if (rx_sh[7:1] == {I2C_ADDR_TOP, i2c_addr})
						begin
							next_st = SER_AACK;
							next_rd_frame = rx_sh[0];
							next_sdrv = 1'b1;
						end
						else
							next_st = SER_IDLE;
					end
				end
				SER_AACK, SER_WACK:
				begin
					if (c_fall)
					begin
						next_bit_cnt = 4'h0;
						next_st = (st == SER_AACK && rd_frame) ? SER_RD : SER_WR;
						next_tx_sh = i_read_data;
						next_sdrv = (st == SER_AACK && rd_frame) ? !i_read_data[7] : 1'b0;
					end
				end
				SER_RD:
				begin
					if (c_fall)
					begin
						next_bit_cnt = bit_cnt + 4'h1;
						next_tx_sh = {tx_sh[6:0], 1'b0};
						next_sdrv = !tx_sh[6];
						if (bit_cnt == 4'h7)
						begin
							next_st = SER_RACK;
							next_sdrv = 1'b0;
							next_bit_cnt = 4'h0;
							s_done = 1'b1;
						end
					end
				end
				SER_RACK:
				begin
					if (c_rise)
					begin
						next_load_pend = !sda;
						if (sda)
							next_st = SER_IDLE;
					end
					else if (c_fall && load_pend)
					begin
						next_load_pend = 1'b0;
						next_st = SER_RD;
						next_tx_sh = i_read_data;
						next_sdrv = !i_read_data[7];
					end
				end
				default:
					next_st = SER_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st <= SER_IDLE;
			bit_cnt <= 4'h0;
			rx_sh <= `MHBP_BYTE_ZERO;
			tx_sh <= `MHBP_BYTE_ZERO;
			first <= 1'b1;
			rd_frame <= 1'b0;
			load_pend <= 1'b0;
			sdrv <= 1'b0;
		end
		else
		begin
			st <= next_st;
			bit_cnt <= next_bit_cnt;
			rx_sh <= next_rx_sh;
			tx_sh <= next_tx_sh;
			first <= next_first;
			rd_frame <= next_rd_frame;
			load_pend <= next_load_pend;
			sdrv <= next_sdrv;
		end
	end

	// Received bytes with their command/data mark pass through the buffer
	mhbp_fifo_if #(.WIDTH(9)) fif();
	mhbp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) mhbp_fifo_i (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.port(fif.fifo)
	);
	assign fifo_ready = fif.in_ready;
	assign fif.in_valid = p_push || s_push;
	// I2C pushes on the ack-slot fall, when the shift register already holds the byte
	assign fif.in_data = p_push ? {cds, bus}
		: (mode == MHBP_I2C) ? {!first, rx_sh} : {!first, rx_new};
	assign fif.out_ready = !o_rx_valid || i_rx_ready;

	// Output registers: pins, wait, interrupt and user stream
	logic [7:0] next_out_bus, next_out_oe;
	logic next_wait_n, next_rx_valid, next_rx_is_data;
	logic [7:0] next_rx_data;
	always_comb
	begin
		next_out_bus = `MHBP_BYTE_ZERO;
		next_out_oe = `MHBP_BYTE_ZERO;
		if (p_read)
		begin
			next_out_bus = rd_value;
			next_out_oe = 8'hFF;
		end
		else if (!bus[`MHBP_SS_BIT] && !host_rst
			&& (mode == MHBP_SPI4 || (mode == MHBP_SPI3 && rd_frame)))
		begin
			next_out_bus[`MHBP_SDO_BIT] = tx_sh[7];
			next_out_oe[`MHBP_SDO_BIT] = 1'b1;
		end
		else if (mode == MHBP_I2C && sdrv)
			next_out_oe[`MHBP_SDA_BIT] = 1'b1;
		next_wait_n = !(host_rst || i_busy || !fif.in_ready);
		next_rx_valid = fif.out_ready ? fif.out_valid : o_rx_valid;
		next_rx_data = (fif.out_ready && fif.out_valid) ? fif.out_data[7:0] : o_rx_data;
		next_rx_is_data = (fif.out_ready && fif.out_valid) ? fif.out_data[8] : o_rx_is_data;
	end

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_host_data_bus <= `MHBP_BYTE_ZERO;
			o_host_data_oe <= `MHBP_BYTE_ZERO;
			o_host_wait_n <= 1'b0;
			o_irq_n <= 1'b1;
			o_host_reset <= 1'b0;
			o_rd_taken <= 1'b0;
			o_rx_valid <= 1'b0;
			o_rx_data <= `MHBP_BYTE_ZERO;
			o_rx_is_data <= 1'b0;
		end
		else
		begin
			o_host_data_bus <= next_out_bus;
			o_host_data_oe <= next_out_oe;
			o_host_wait_n <= next_wait_n;
			o_irq_n <= !i_irq_req;
			o_host_reset <= host_rst;
			o_rd_taken <= p_done || s_done;
			o_rx_valid <= next_rx_valid;
			o_rx_data <= next_rx_data;
			o_rx_is_data <= next_rx_is_data;
		end
	end
endmodule : mhbp_port

// file: tb/mhbp_port_checker.sv
`timescale 1ns/1ps
module mhbp_port_checker
#(
	parameter int RST_HOLD_CYCLES = 8
)
(
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [7:0] i_host_data_bus,
	input wire logic [7:0] o_host_data_oe,
	input wire logic i_parallel_select_n,
	input wire logic i_host_reset_n,
	input wire logic [2:0] i_bus_mode_strap,
	input wire logic o_host_wait_n,
	input wire logic o_irq_n,
	input wire logic o_host_reset,
	input wire logic i_busy,
	input wire logic i_irq_req,
	input wire logic o_rx_valid,
	input wire logic [7:0] o_rx_data,
	input wire logic i_rx_ready
);
	logic [15:0] low_cnt;
	logic [15:0] next_low_cnt;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_nrst);

	// Length of the current low run on the host reset pin, saturating
	always_comb
	begin
		next_low_cnt = low_cnt;
		if (i_host_reset_n)
			next_low_cnt = 16'h0000;
		else if (low_cnt != 16'hFFFF)
			next_low_cnt = low_cnt + 16'h0001;
	end

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
			low_cnt <= 16'h0000;
		else
			low_cnt <= next_low_cnt;
	end

	// Eight-cycle stretches: parallel select idle, serial select idle and serial select active
	sequence sel_idle;
		i_parallel_select_n [*8];
	endsequence
	sequence ss_idle;
		i_host_data_bus[4] [*8];
	endsequence
	sequence ss_active;
		!i_host_data_bus[4] [*8];
	endsequence

	a_busy_wait: assert property (i_busy |=> !o_host_wait_n)
		else $error("wait not low while busy");
	a_irq_level: assert property (i_irq_req [*2] |-> !o_irq_n)
		else $error("irq not low on request");
	a_par_oe: assert property (!i_bus_mode_strap[2] |-> o_host_data_oe inside {8'h00, 8'hFF})
		else $error("partial bus drive in parallel mode");
	a_sel_block: assert property ((!i_bus_mode_strap[2] ##0 sel_idle) |-> o_host_data_oe == 8'h00)
		else $error("bus driven without select");
	a_serial_quiet: assert property ((i_bus_mode_strap[2:1] == 2'b10 ##0 ss_idle) |-> !$rose(o_rx_valid))
		else $error("byte received while deselected");
	a_spi_out: assert property ((i_bus_mode_strap == 3'h5 ##0 ss_active) |-> ##2 o_host_data_oe == 8'h20)
		else $error("serial out not driven");
	a_rx_hold: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
		else $error("received byte lost before taken");
	a_rst_early: assert property ($rose(o_host_reset) |-> low_cnt >= RST_HOLD_CYCLES)
		else $error("host reset taken too early");
	a_rst_late: assert property (low_cnt == RST_HOLD_CYCLES + 8 |-> o_host_reset)
		else $error("host reset not taken");
endmodule : mhbp_port_checker

bind mhbp_port mhbp_port_checker #(.RST_HOLD_CYCLES(RST_HOLD_CYCLES)) mhbp_port_checker_i (
	.i_clock(i_clock), .i_nrst(i_nrst), .i_host_data_bus(i_host_data_bus),
	.o_host_data_oe(o_host_data_oe), .i_parallel_select_n(i_parallel_select_n),
	.i_host_reset_n(i_host_reset_n), .i_bus_mode_strap(i_bus_mode_strap),
	.o_host_wait_n(o_host_wait_n), .o_irq_n(o_irq_n), .o_host_reset(o_host_reset),
	.i_busy(i_busy), .i_irq_req(i_irq_req), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
	.i_rx_ready(i_rx_ready));

// file: tb/mhbp_host_model.sv
`timescale 1ns/1ps
module mhbp_host_model
(
	input wire logic i_clock,
	input wire logic [7:0] i_bus,
	input wire logic i_wait_n,
	output logic [7:0] o_bus,
	output logic [7:0] o_bus_oe,
	output logic o_cds,
	output logic o_wr_n,
	output logic o_rd_n,
	output logic o_sel_n
);
	// Every pin starts released to its pull-up
	initial
	begin
		o_bus = 8'hFF;
		o_bus_oe = 8'h00;
		o_cds = 1'b1;
		o_wr_n = 1'b1;
		o_rd_n = 1'b1;
		o_sel_n = 1'b1;
	end

	// Wait whole clocks, then move just after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : tick

	// One parallel cycle; strobes stay wide so the filtered levels settle
	task automatic cycle(input logic m6800, input logic rd, input logic sel, input logic cds,
		input logic [7:0] wdat, output logic [7:0] rdat);
		for (int n = 0; n < 2000 && i_wait_n !== 1'b1; n++)
			tick(1);
		o_rd_n = !m6800;
		tick(10);
		o_sel_n = !sel;
		o_cds = cds;
		o_wr_n = m6800 ? rd : 1'b1;
		o_bus = wdat; // Eight-bit width only
		o_bus_oe = rd ? 8'h00 : 8'hFF;
		tick(10);
		if (m6800)
			o_rd_n = 1'b1;
		else if (rd)
			o_rd_n = 1'b0;
		else
			o_wr_n = 1'b0;
		tick(14);
		rdat = i_bus;
		o_rd_n = !m6800;
		o_wr_n = m6800 ? rd : 1'b1;
		tick(10);
		o_sel_n = 1'b1;
		o_bus_oe = 8'h00;
		tick(5);
		o_wr_n = 1'b1;
		o_rd_n = 1'b1;
		o_cds = 1'b1;
		tick(5);
	endtask : cycle

	// Two-byte frame in mode 0; clock and select stand still outside it
	task automatic spi2(input logic w3, input logic [15:0] bits, output logic [15:0] got);
		o_bus = 8'h5F;
		o_bus_oe = 8'hDF;
		tick(10);
		o_bus[4] = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			o_bus_oe[5] = w3 && !(bits[15] && i < 8);
			o_bus[w3 ? 5 : 6] = bits[i];
			tick(10);
			o_bus[7] = 1'b1;
			got[i] = i_bus[5];
			if (w3 && bits[15] && i == 8)
				o_bus_oe[5] = 1'b0; // Hand the line over before the device answers
			tick(10);
			o_bus[7] = 1'b0;
		end
		tick(10);
		o_bus[4] = 1'b1;
		tick(10);
		o_bus_oe = 8'h00;
	endtask : spi2

	// Write frame: address byte, data byte, stop; SDA is open drain
	task automatic i2c_wr(input logic [7:0] adr, input logic [7:0] dat, output logic [1:0] acks);
		logic [17:0] bits;
		bits = {adr, 1'b1, dat, 1'b1};
		o_bus = 8'hBF;
		o_bus_oe = 8'h80;
		tick(10);
		o_bus_oe[6] = 1'b1;
		tick(10);
		o_bus[7] = 1'b0;
		for (int i = 17; i >= 0; i--)
		begin
			o_bus_oe[6] = !bits[i];
			tick(10);
			o_bus[7] = 1'b1;
			if (i == 9)
				acks[1] = i_bus[6];
			if (i == 0)
				acks[0] = i_bus[6];
			tick(10);
			o_bus[7] = 1'b0;
		end
		o_bus_oe[6] = 1'b1;
		tick(10);
		o_bus[7] = 1'b1;
		tick(10);
		o_bus_oe[6] = 1'b0;
		tick(10);
		o_bus_oe = 8'h00;
	endtask : i2c_wr
endmodule : mhbp_host_model

// file: tb/multimode_host_bus_port_tb.sv
`timescale 1ns/1ps
module multimode_host_bus_port_tb;
	localparam logic [7:0] STATUS = 8'h3C;
	localparam logic [7:0] RDATA = 8'hC3;
	logic clk, nrst, host_rst_n, busy, irq_req, rx_ready, cds, wr_n, rd_n, sel_n;
	logic wait_n, irq_n, host_reset, rd_taken, rx_valid, rx_is_data;
	logic [2:0] strap;
	logic [7:0] dout, doe, h_bus, h_oe, bus, rx_data, rd_val;
	logic [8:0] rxq[$];
	int error_cnt, comparisons, cycles, rd_cnt;

	// Pins carry pull-ups; the device wins where it drives
	assign bus = (doe & dout) | (~doe & h_oe & h_bus) | ~(doe | h_oe);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	mhbp_port #(.RST_HOLD_CYCLES(8)) mhbp_port_i (.i_clock(clk), .i_nrst(nrst), .i_host_data_bus(bus),
		.o_host_data_bus(dout), .o_host_data_oe(doe), .i_cmd_data_sel(cds), .i_write_strobe_n(wr_n),
		.i_read_strobe_n(rd_n), .i_parallel_select_n(sel_n), .i_host_reset_n(host_rst_n),
		.i_bus_mode_strap(strap), .o_host_wait_n(wait_n), .o_irq_n(irq_n), .o_host_reset(host_reset),
		.i_busy(busy), .i_irq_req(irq_req), .i_status_word(STATUS), .i_read_data(RDATA),
		.o_rd_taken(rd_taken), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_is_data(rx_is_data),
		.i_rx_ready(rx_ready));

	mhbp_host_model mhbp_host_model_i (.i_clock(clk), .i_bus(bus), .i_wait_n(wait_n), .o_bus(h_bus),
		.o_bus_oe(h_oe), .o_cds(cds), .o_wr_n(wr_n), .o_rd_n(rd_n), .o_sel_n(sel_n));

	// Collect handed-over bytes and read pulses; cut a hang short
	always @(posedge clk)
	begin
		cycles++;
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			rxq.push_back({rx_is_data, rx_data});
		if (rd_taken === 1'b1)
			rd_cnt++;
		if (cycles == 40000)
		begin
			error_cnt++;
			test_done();
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic do_reset(input logic [2:0] mode);
		nrst = 1'b0;
		strap = mode;
		step(2);
		nrst = 1'b1;
		step(12);
		rxq.delete();
		rd_cnt = 0;
	endtask : do_reset

	// Writes with and without select, then a status read and a data read
	task automatic t_parallel(input logic [2:0] mode);
		do_reset(mode);
		mhbp_host_model_i.cycle(mode[1], 1'b0, 1'b1, 1'b0, 8'hA5, rd_val);
		mhbp_host_model_i.cycle(mode[1], 1'b0, 1'b1, 1'b1, 8'h5A, rd_val);
		mhbp_host_model_i.cycle(mode[1], 1'b0, 1'b0, 1'b1, 8'hFF, rd_val);
		check("rx count", 9'(rxq.size()), 9'h002);
		check("rx cmd", rxq[0], 9'h0A5);
		check("rx data", rxq[1], 9'h15A);
		mhbp_host_model_i.cycle(mode[1], 1'b1, 1'b1, 1'b0, 8'h00, rd_val);
		check("status", {1'b0, rd_val}, {1'b0, STATUS});
		mhbp_host_model_i.cycle(mode[1], 1'b1, 1'b1, 1'b1, 8'h00, rd_val);
		check("read data", {1'b0, rd_val}, {1'b0, RDATA});
		check("read pulses", 9'(rd_cnt), 9'h002);
		$display("parallel mode %0d done", mode);
	endtask : t_parallel

	// Parallel traffic in a serial mode must leave the port untouched
	task automatic t_ignored(input logic [2:0] mode);
		do_reset(mode);
		mhbp_host_model_i.cycle(1'b0, 1'b0, 1'b1, 1'b1, 8'h5A, rd_val);
		mhbp_host_model_i.cycle(1'b0, 1'b1, 1'b1, 1'b1, 8'h00, rd_val);
		check("serial rx", 9'(rxq.size()), 9'h000);
		check("serial read", {1'b0, rd_val}, 9'h0FF);
		$display("serial mode %0d ignores strobes", mode);
	endtask : t_ignored

	// Write frame then read frame over the serial pins
	task automatic t_spi(input logic w3);
		logic [15:0] got;
		do_reset({2'b10, !w3});
		mhbp_host_model_i.spi2(w3, 16'h1234, got);
		step(20);
		check("spi cmd", rxq[0], 9'h012);
		check("spi data", rxq[1], 9'h134);
		mhbp_host_model_i.spi2(w3, 16'h8000, got);
		check("spi read", {1'b0, got[7:0]}, {1'b0, RDATA});
		$display("spi three wire %0d done", w3);
	endtask : t_spi

	// Addressed write lands as a command byte; a foreign address is refused
	task automatic t_i2c();
		logic [1:0] acks;
		do_reset(3'h6);
		mhbp_host_model_i.i2c_wr(8'h7E, 8'h96, acks);
		step(10);
		check("i2c acks", {7'h00, acks}, 9'h000);
		check("i2c byte", rxq[0], 9'h096);
		mhbp_host_model_i.i2c_wr(8'h70, 8'h69, acks);
		step(10);
		check("i2c nack", {7'h00, acks}, 9'h003);
		check("i2c count", 9'(rxq.size()), 9'h001);
		$display("i2c done");
	endtask : t_i2c

	// Stall the consumer until the buffer refuses, then drain it in order
	task automatic t_fill();
		int k;
		do_reset(3'h0);
		rx_ready = 1'b0;
		for (k = 0; k < 6 && wait_n === 1'b1; k++)
			mhbp_host_model_i.cycle(1'b0, 1'b0, 1'b1, 1'b1, 8'h10 + 8'(k), rd_val);
		check("full wait", {8'h00, wait_n}, 9'h000);
		check("depth", {8'h00, k >= 4}, 9'h001);
		rx_ready = 1'b1;
		step(30);
		check("drained", 9'(rxq.size()), 9'(k));
		for (int i = 0; i < k; i++)
			check("order", rxq[i], 9'h110 + 9'(i));
		check("ready wait", {8'h00, wait_n}, 9'h001);
		$display("buffer fill done");
	endtask : t_fill

	// Busy, interrupt and host reset levels at the port
	task automatic t_status();
		busy = 1'b1;
		step(3);
		check("busy wait", {8'h00, wait_n}, 9'h000);
		busy = 1'b0;
		irq_req = 1'b1;
		step(3);
		check("wait back", {8'h00, wait_n}, 9'h001);
		check("irq on", {8'h00, irq_n}, 9'h000);
		irq_req = 1'b0;
		host_rst_n = 1'b0;
		step(4);
		host_rst_n = 1'b1;
		step(12);
		check("short reset", {8'h00, host_reset}, 9'h000);
		check("irq off", {8'h00, irq_n}, 9'h001);
		host_rst_n = 1'b0;
		step(20);
		check("long reset", {8'h00, host_reset}, 9'h001);
		host_rst_n = 1'b1;
		step(12);
		check("reset gone", {8'h00, host_reset}, 9'h000);
		$display("status levels done");
	endtask : t_status

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	initial
	begin
		nrst = 1'b0;
		strap = 3'h0;
		host_rst_n = 1'b1;
		busy = 1'b0;
		irq_req = 1'b0;
		rx_ready = 1'b1;
		t_parallel(3'h0);
		t_parallel(3'h1);
		t_parallel(3'h2);
		t_parallel(3'h3);
		t_status();
		t_fill();
		t_spi(1'b0);
		t_spi(1'b1);
		t_i2c();
		t_ignored(3'h4);
		t_ignored(3'h6);
		t_ignored(3'h7);
		test_done();
	end
endmodule : multimode_host_bus_port_tb
